/* File: verilog/rtcb_timebase_ctrl.sv */
`include "rtcb_params.svh"

module rtcb_timebase_ctrl #(
  parameter int unsigned BLANK_CYCLES = `RTCB_BLANK_MS * 1000 * `RTCB_CLK_MHZ,
  parameter int unsigned MISS_CYCLES = `RTCB_MISS_US * `RTCB_CLK_MHZ
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Software configuration
  input wire rtcb_pkg::rtcb_cfg_s cfg,
  input wire logic osc_fail_clear,
  // Oscillator side inputs, asynchronous
  input wire logic osc_pin_in,
  input wire logic lfo_clk_in,
  input wire logic amp_detect_in,
  // Oscillator steering
  output rtcb_pkg::rtcb_ana_s ana_q,
  // Timebase toward the timer
  output rtcb_pkg::rtcb_src_e src_q,
  output logic tick_q,
  output logic [1:0] inc_weight_q,
  // Status
  output logic load_cap_ready_flag_q,
  output logic crystal_valid_flag_q,
  output logic osc_fail_flag_q
);
  import rtcb_pkg::*;

  localparam logic [`RTCB_CNT_W-1:0] BLANK_LIM = `RTCB_CNT_W'(BLANK_CYCLES);
  localparam logic [`RTCB_CNT_W-1:0] MISS_LIM = `RTCB_CNT_W'(MISS_CYCLES);
  localparam logic [`RTCB_CNT_W-1:0] STEP_LIM = `RTCB_CNT_W'(`RTCB_STEP_OSC_CYCLES);
  localparam logic [`RTCB_CNT_W-1:0] CNT_ONE = `RTCB_CNT_W'(1);

  // Reset release through two flops
  logic rst_m_q;
  logic rst_sync_b;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_sync_b <= rst_m_q;
    end
  end

  // Pin-side levels
  logic osc_lvl;
  logic lfo_lvl;
  logic amp_lvl;
  rtcb_pin_sync u_sync_osc (.clock(clock), .rst_sync_b(rst_sync_b), .din(osc_pin_in),
    .lvl_q(osc_lvl));
  rtcb_pin_sync u_sync_lfo (.clock(clock), .rst_sync_b(rst_sync_b), .din(lfo_clk_in),
    .lvl_q(lfo_lvl));
  rtcb_pin_sync u_sync_amp (.clock(clock), .rst_sync_b(rst_sync_b), .din(amp_detect_in),
    .lvl_q(amp_lvl));

  // Registered copies for edge detection
  logic osc_lvl_q;
  logic lfo_lvl_q;
  logic pwr_q;
  logic mode_sel_q;
  logic astep_q;
  logic [`RTCB_LOAD_W-1:0] sel_q;

  // Timebase selection; the LOW_FREQ_OSCILLATOR wins because enabling it also selects it
  // source select
  rtcb_src_e src_d;
  assign src_d = cfg.low_freq_osc_enable ? RTCB_SRC_LFO :
                 !cfg.osc_power_enable ? RTCB_SRC_NONE :
                 cfg.crystal_mode_select ? RTCB_SRC_XTAL : RTCB_SRC_SELF;

  // Rising edges of each source; the CMOS clock arrives on the same pin
  wire osc_rise = osc_lvl && !osc_lvl_q;
  wire lfo_rise = lfo_lvl && !lfo_lvl_q;
  logic sel_rise;
  logic sel_lvl;
  always_comb begin
    sel_rise = 1'b0;
    sel_lvl = 1'b0;
    unique case (src_q)
      RTCB_SRC_NONE: sel_rise = 1'b0;
      RTCB_SRC_LFO: begin
        sel_rise = lfo_rise;
        sel_lvl = lfo_lvl;
      end
      RTCB_SRC_XTAL, RTCB_SRC_SELF: begin
        sel_rise = osc_rise;
        sel_lvl = osc_lvl;
      end
      default: sel_rise = 1'b0;
    endcase
  end

  // Steering decode
  // short pins
  wire short_d = cfg.osc_power_enable && !cfg.crystal_mode_select;
  wire bias_d = cfg.bias_double_enable;
  // Gain control only reaches the circuit in crystal mode, protecting self-oscillation
  // gain gated
  wire gain_d = cfg.gain_control_enable && cfg.crystal_mode_select;

  // Restart events for load stepping and blanking
  wire pwr_rise = cfg.osc_power_enable && !pwr_q;
  wire mode_chg = cfg.crystal_mode_select != mode_sel_q;
  wire astep_rise = cfg.autostep_enable && !astep_q;
  wire step_restart = pwr_rise || astep_rise;
  wire sel_chg = cfg.load_cap_select != sel_q;

  // Step interval counter, advanced by oscillator edges
  // step period
  logic [`RTCB_CNT_W-1:0] step_cnt_q;
  wire step_due = osc_rise && (step_cnt_q >= STEP_LIM - CNT_ONE);
  wire [`RTCB_CNT_W-1:0] step_cnt_d = step_restart || step_due ? '0 :
                                     osc_rise ? step_cnt_q + CNT_ONE : step_cnt_q;

  // Applied load; stepping down is immediate, as a lower load never slows start-up
  // load code
  logic [`RTCB_LOAD_W-1:0] load_q;
  wire [`RTCB_LOAD_W-1:0] load_inc = load_q + `RTCB_LOAD_W'(1);
  wire [`RTCB_LOAD_W-1:0] load_d =
    !cfg.autostep_enable ? cfg.load_cap_select :
    step_restart ? `RTCB_LOAD_MIN :
    (load_q > cfg.load_cap_select) ? cfg.load_cap_select :
    (step_due && load_q < cfg.load_cap_select) ? load_inc : load_q;

  // Ready follows the applied load one cycle later
  // ready set
  wire ready_d = !step_restart && !sel_chg && (load_q == sel_q);

  // Crystal-valid blanking counter
  // blank window
  logic [`RTCB_CNT_W-1:0] blank_cnt_q;
  wire xtal_on = cfg.osc_power_enable && cfg.crystal_mode_select;
  wire blank_done = blank_cnt_q >= BLANK_LIM;
  wire [`RTCB_CNT_W-1:0] blank_cnt_d = (!xtal_on || pwr_rise || mode_chg) ? '0 :
                                      blank_done ? blank_cnt_q : blank_cnt_q + CNT_ONE;
  wire valid_d = cfg.bias_double_enable && xtal_on && blank_done && amp_lvl;

  // Missing-clock detector on the selected timebase level
  // stuck detect
  logic [`RTCB_CNT_W-1:0] miss_cnt_q;
  logic sel_lvl_q;
  wire sel_edge = sel_lvl != sel_lvl_q;
  wire miss_hit = cfg.missing_clk_enable && (miss_cnt_q >= MISS_LIM);
  wire [`RTCB_CNT_W-1:0] miss_cnt_d = (!cfg.missing_clk_enable || sel_edge) ? '0 :
                                     miss_hit ? miss_cnt_q : miss_cnt_q + CNT_ONE;
  // A set in the clearing cycle wins
  wire fail_d = miss_hit || (osc_fail_flag_q && !osc_fail_clear);

  // LOW_FREQ_OSCILLATOR ticks weigh two so the count rate matches a crystal
  // double weight
  wire [1:0] weight_d = (src_q == RTCB_SRC_LFO) ? `RTCB_INC_BIT1 : `RTCB_INC_BIT0;

  // Edge and history registers
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      osc_lvl_q <= 1'b0;
      lfo_lvl_q <= 1'b0;
      sel_lvl_q <= 1'b0;
      pwr_q <= 1'b0;
      mode_sel_q <= 1'b0;
      astep_q <= 1'b0;
      sel_q <= `RTCB_LOAD_MIN;
    end else begin
      osc_lvl_q <= osc_lvl;
      lfo_lvl_q <= lfo_lvl;
      sel_lvl_q <= sel_lvl;
      pwr_q <= cfg.osc_power_enable;
      mode_sel_q <= cfg.crystal_mode_select;
      astep_q <= cfg.autostep_enable;
      sel_q <= cfg.load_cap_select;
    end
  end

  // Counters and load state
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      step_cnt_q <= '0;
      blank_cnt_q <= '0;
      miss_cnt_q <= '0;
      load_q <= `RTCB_LOAD_MIN;
    end else begin
      step_cnt_q <= step_cnt_d;
      blank_cnt_q <= blank_cnt_d;
      miss_cnt_q <= miss_cnt_d;
      load_q <= load_d;
    end
  end

  // Output registers
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ana_q <= '0;
      src_q <= RTCB_SRC_NONE;
      tick_q <= 1'b0;
      inc_weight_q <= `RTCB_INC_BIT0;
      load_cap_ready_flag_q <= 1'b0;
      crystal_valid_flag_q <= 1'b0;
      osc_fail_flag_q <= 1'b0;
    end else begin
      ana_q <= '{short_d, bias_d, gain_d, cfg.low_freq_osc_enable,
                 cfg.osc_power_enable, load_d};
      src_q <= src_d;
      tick_q <= sel_rise;
      inc_weight_q <= weight_d;
      load_cap_ready_flag_q <= ready_d;
      crystal_valid_flag_q <= valid_d;
      osc_fail_flag_q <= fail_d;
    end
  end

  property p_lfo_select;
    @(posedge clock) disable iff (!rst_sync_b)
      cfg.low_freq_osc_enable |=> (src_q == RTCB_SRC_LFO);
  endproperty
  a_lfo_select: assert property (p_lfo_select) else $error("LOW_FREQ_OSCILLATOR not selected");
  property p_short;
    @(posedge clock) disable iff (!rst_sync_b)
      $rose(ana_q.pins_shorted) |-> $past(cfg.osc_power_enable && !cfg.crystal_mode_select);
  endproperty
  a_short: assert property (p_short) else $error("Pins shorted outside self mode");
  property p_weight;
    @(posedge clock) disable iff (!rst_sync_b)
      (src_q == RTCB_SRC_LFO) |=> (inc_weight_q == `RTCB_INC_BIT1);
  endproperty
  a_weight: assert property (p_weight) else $error("LOW_FREQ_OSCILLATOR tick weight wrong");
  property p_valid_low;
    @(posedge clock) disable iff (!rst_sync_b)
      !cfg.bias_double_enable |=> !crystal_valid_flag_q;
  endproperty
  a_valid_low: assert property (p_valid_low) else $error("Valid without bias double");
  property p_blank;
    @(posedge clock) disable iff (!rst_sync_b)
      crystal_valid_flag_q |-> ($past(blank_cnt_q) >= BLANK_LIM);
  endproperty
  a_blank: assert property (p_blank) else $error("Valid inside blanking");
  property p_step_one;
    @(posedge clock) disable iff (!rst_sync_b)
      (cfg.autostep_enable && $past(cfg.autostep_enable) && load_q > $past(load_q))
        |-> (load_q == $past(load_q) + `RTCB_LOAD_W'(1));
  endproperty
  a_step_one: assert property (p_step_one) else $error("Load stepped by more than one");
  property p_ready;
    @(posedge clock) disable iff (!rst_sync_b)
      load_cap_ready_flag_q |-> ($past(load_q) == $past(sel_q));
  endproperty
  a_ready: assert property (p_ready) else $error("Ready before load reached");
  property p_ready_clr;
    @(posedge clock) disable iff (!rst_sync_b)
      sel_chg |=> !load_cap_ready_flag_q;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("Ready kept after new value");
  property p_fail;
    @(posedge clock) disable iff (!rst_sync_b)
      miss_hit |=> osc_fail_flag_q;
  endproperty
  a_fail: assert property (p_fail) else $error("Stuck clock not flagged");
  property p_gain;
    @(posedge clock) disable iff (!rst_sync_b)
      !cfg.crystal_mode_select |=> !ana_q.gain_control;
  endproperty
  a_gain: assert property (p_gain) else $error("Gain control in self mode");
  c_ready: cover property (@(posedge clock) $rose(load_cap_ready_flag_q));
  c_valid: cover property (@(posedge clock) $rose(crystal_valid_flag_q));
  c_fail: cover property (@(posedge clock) $rose(osc_fail_flag_q));
  c_lfo_tick: cover property (@(posedge clock) tick_q && src_q == RTCB_SRC_LFO);

endmodule // rtcb_timebase_ctrl

/* File: verilog/rtcb_params.svh */
`ifndef RTCB_PARAMS_SVH
`define RTCB_PARAMS_SVH

// System clock rate in MHz (4 ns period)
`define RTCB_CLK_MHZ 250
// Crystal-valid blanking time after crystal start, in ms
`define RTCB_BLANK_MS 2
// Missing-clock limit on a stuck level, in us
`define RTCB_MISS_US 100
// Oscillator cycles between two load steps
`define RTCB_STEP_OSC_CYCLES 16
// Load capacitance code width and the end codes
`define RTCB_LOAD_W 4
`define RTCB_LOAD_MIN 4'h0
`define RTCB_LOAD_MAX 4'hf
// Timer increment weights: bit 0 or bit 1
`define RTCB_INC_BIT0 2'h1
`define RTCB_INC_BIT1 2'h2
// Width of the long cycle counters
`define RTCB_CNT_W 32

`endif

/* File: verilog/rtcb_pkg.sv */
`include "rtcb_params.svh"

package rtcb_pkg;

  // Timebase source, one-hot
  typedef enum logic [3:0] {
    RTCB_SRC_NONE = 4'h1,
    RTCB_SRC_LFO = 4'h2,
    RTCB_SRC_XTAL = 4'h4,
    RTCB_SRC_SELF = 4'h8
  } rtcb_src_e;

  // Software configuration bits
  typedef struct packed {
    logic crystal_mode_select;
    logic gain_control_enable;
    logic bias_double_enable;
    logic osc_power_enable;
    logic low_freq_osc_enable;
    logic autostep_enable;
    logic missing_clk_enable;
    logic [`RTCB_LOAD_W-1:0] load_cap_select;
  } rtcb_cfg_s;

  // Analog steering bits toward the oscillator circuit
  typedef struct packed {
    logic pins_shorted;
    logic bias_double;
    logic gain_control;
    logic lfo_run;
    logic osc_run;
    logic [`RTCB_LOAD_W-1:0] load_cap_applied;
  } rtcb_ana_s;

endpackage : rtcb_pkg

/* File: verilog/rtcb_pin_sync.sv */
// Three-stage synchroniser; the level moves once stages two and three agree
module rtcb_pin_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_sync_b,
  // Asynchronous input and filtered level
  input wire logic din,
  output logic lvl_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // The first stage feeds only the second
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q == s3_q) ? s3_q : lvl_q;
    end
  end

endmodule // rtcb_pin_sync

/* File: tb/rtcb_osc_model.sv */
// Crystal, CMOS clock and LOW_FREQ_OSCILLATOR source as seen from the block's pins
module rtcb_osc_model #(
  parameter int HALF_NS = 40,
  parameter int AMP_NS = 100
) (
  // Run requests from the block and the stuck control from the test
  input wire logic osc_run,
  input wire logic lfo_run,
  input wire logic stuck,
  // Waveforms toward the block
  output logic osc_pin,
  output logic lfo_clk,
  output logic amp_ok
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet levels at time zero
  initial begin
    osc_pin = 1'b0;
    lfo_clk = 1'b0;
    amp_ok = 1'b0;
  end

  // external timebase waveform
  // A stuck crystal holds its last level, which the fail detector must catch
  always #(HALF_NS) osc_pin = (osc_run && !stuck) ? ~osc_pin : osc_pin;

  always #(HALF_NS * 4) lfo_clk = lfo_run ? ~lfo_clk : 1'b0;

  // Amplitude builds some time after power, drops at once without it
  always @(posedge osc_run) #(AMP_NS) amp_ok = osc_run;
  always @(negedge osc_run) amp_ok = 1'b0;
endmodule // rtcb_osc_model

/* File: tb/test_rtcb_timebase_ctrl.sv */
module test_rtcb_timebase_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import rtcb_pkg::*;
  localparam int BLANK = 50;
  localparam int MISS = 40;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  rtcb_cfg_s cfg = '0;
  rtcb_cfg_s c_v;
  logic osc_fail_clear = 1'b0;
  logic stuck = 1'b0;
  logic osc_pin_in;
  logic lfo_clk_in;
  logic amp_detect_in;
  rtcb_ana_s ana_q;
  rtcb_src_e src_q;
  logic tick_q;
  logic [1:0] inc_weight_q;
  logic load_cap_ready_flag_q;
  logic crystal_valid_flag_q;
  logic osc_fail_flag_q;
  int bad_count = 0;
  int comparisons = 0;
  int ticks = 0;
  logic step_watch = 1'b0;
  logic [3:0] prev_load = 4'h0;

  // 250 MHz system clock
  always #2 clock = ~clock;

  // Short blanking and miss limits keep the run brief
  rtcb_timebase_ctrl #(.BLANK_CYCLES(BLANK), .MISS_CYCLES(MISS)) i_rtcb_timebase_ctrl (
    .clock(clock), .rst_b(rst_b), .cfg(cfg), .osc_fail_clear(osc_fail_clear),
    .osc_pin_in(osc_pin_in), .lfo_clk_in(lfo_clk_in), .amp_detect_in(amp_detect_in),
    .ana_q(ana_q), .src_q(src_q), .tick_q(tick_q), .inc_weight_q(inc_weight_q),
    .load_cap_ready_flag_q(load_cap_ready_flag_q),
    .crystal_valid_flag_q(crystal_valid_flag_q), .osc_fail_flag_q(osc_fail_flag_q));

  rtcb_osc_model i_rtcb_osc_model (
    .osc_run(ana_q.osc_run), .lfo_run(ana_q.lfo_run), .stuck(stuck),
    .osc_pin(osc_pin_in), .lfo_clk(lfo_clk_in), .amp_ok(amp_detect_in));

  task finish_test;
    $display("Counts: %0d mismatches in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // New configuration lands just after a rising edge
  task apply;
    @(posedge clock);
    cfg <= c_v;
  endtask

  function logic flag(input int w);
    case (w)
      0: flag = crystal_valid_flag_q;
      1: flag = load_cap_ready_flag_q;
      default: flag = osc_fail_flag_q;
    endcase
  endfunction

  task wait_flag(input int w, input int max);
    int i;
    for (i = 0; i < max && flag(w) !== 1'b1; i++) @(negedge clock);
    comparisons++;
    if (flag(w) !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: flag %0d never rose", $time, w);
      finish_test();
    end
  endtask

  // Ticks counted and load steps watched on the settled half of the clock
  always @(negedge clock) begin
    if (tick_q === 1'b1) ticks++;
    if (step_watch && ana_q.load_cap_applied !== prev_load &&
        ana_q.load_cap_applied !== prev_load + 4'h1) begin
      bad_count++;
      $display("MISMATCH at %0t: load jumped from %h", $time, prev_load);
    end
    prev_load <= ana_q.load_cap_applied;
  end

  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    cyc(8);
    check(src_q, RTCB_SRC_NONE, "src reset");
    check(inc_weight_q, 2'h1, "weight reset");
    // Load equals select out of reset, so ready already stands
    check({load_cap_ready_flag_q, crystal_valid_flag_q, osc_fail_flag_q}, 3'h4, "flags");
    // Self-oscillate with gain control kept off
    c_v = '0;
    c_v.osc_power_enable = 1'b1;
    apply();
    cyc(20);
    check(src_q, RTCB_SRC_SELF, "self src");
    check(ana_q.pins_shorted, 1'b1, "pins shorted");
    check(ana_q.bias_double, 1'b0, "bias off");
    check(crystal_valid_flag_q, 1'b0, "valid self");
    ticks = 0;
    cyc(400);
    check(ticks >= 19 && ticks <= 21, 1'b1, "self ticks");
    c_v.bias_double_enable = 1'b1;
    apply();
    cyc(4);
    check(ana_q.bias_double, 1'b1, "bias on");
    // LOW_FREQ_OSCILLATOR takes over the timebase and doubles the weight
    c_v.low_freq_osc_enable = 1'b1;
    apply();
    cyc(4);
    check(src_q, RTCB_SRC_LFO, "lfo src");
    check(inc_weight_q, 2'h2, "lfo weight");
    ticks = 0;
    cyc(400);
    check(ticks >= 4 && ticks <= 6, 1'b1, "lfo ticks");
    c_v = '0;
    apply();
    cyc(4);
    check(inc_weight_q, 2'h1, "weight back");
    // Crystal start: mode, gain off, bias on, load, then power
    c_v.crystal_mode_select = 1'b1;
    c_v.bias_double_enable = 1'b1;
    c_v.load_cap_select = 4'h5;
    c_v.autostep_enable = 1'b1;
    apply();
    cyc(2);
    c_v.osc_power_enable = 1'b1;
    apply();
    cyc(3);
    check(ana_q.load_cap_applied, 4'h0, "load start");
    check(load_cap_ready_flag_q, 1'b0, "ready restart");
    check(src_q, RTCB_SRC_XTAL, "xtal src");
    check(ana_q.pins_shorted, 1'b0, "pins apart");
    step_watch = 1'b1;
    repeat (40) begin
      check(crystal_valid_flag_q, 1'b0, "blanked");
      cyc(1);
    end
    wait_flag(0, 200);
    wait_flag(1, 3000);
    check(ana_q.load_cap_applied, 4'h5, "load final");
    c_v.load_cap_select = 4'hf;
    apply();
    cyc(4);
    check(load_cap_ready_flag_q, 1'b0, "ready drops");
    wait_flag(1, 5000);
    check(ana_q.load_cap_applied, 4'hf, "load max");
    step_watch = 1'b0;
    // Trim for power and arm the missing-clock detector
    c_v.gain_control_enable = 1'b1;
    c_v.bias_double_enable = 1'b0;
    c_v.missing_clk_enable = 1'b1;
    apply();
    cyc(4);
    check(ana_q.gain_control, 1'b1, "gain on");
    check(crystal_valid_flag_q, 1'b0, "valid low");
    cyc(60);
    check(osc_fail_flag_q, 1'b0, "no fail");
    stuck = 1'b1;
    cyc(25);
    check(osc_fail_flag_q, 1'b0, "fail early");
    wait_flag(2, 30);
    stuck = 1'b0;
    cyc(30);
    @(posedge clock);
    osc_fail_clear <= 1'b1;
    @(posedge clock);
    osc_fail_clear <= 1'b0;
    cyc(4);
    check(osc_fail_flag_q, 1'b0, "fail cleared");
    // External clock setup: lowest bias with gain control off, fail must stay low
    c_v.gain_control_enable = 1'b0;
    apply();
    cyc(60);
    check(ana_q.gain_control, 1'b0, "cmos gain off");
    check(ana_q.bias_double, 1'b0, "cmos bias low");
    check(osc_fail_flag_q, 1'b0, "cmos clock present");
    finish_test();
  end
endmodule // test_rtcb_timebase_ctrl
